// ### common/dlb_pkg.sv
// Shared constants, register map and types of the pattern/trim block
package dlb_pkg;

   // ===================================================================
   // Bus and register window
   localparam logic [1:0] TRANS_NONSEQ = 2'b10;
   localparam logic HRESP_OKAY = 1'b0;
   localparam logic [6:0] IDX_BASE = 7'h30;
   localparam int SLOTS = 32;

   // ===================================================================
   // Register indices (byte address is four times the index)
   localparam logic [6:0] IDX_A_HBP = 7'h34;
   localparam logic [6:0] IDX_B_HBP = 7'h35;
   localparam logic [6:0] IDX_A_VBP = 7'h36;
   localparam logic [6:0] IDX_SECOND_CHANNEL_LINES_AFTER_VSYNC = 7'h37;
   localparam logic [6:0] IDX_FIRST_CHANNEL_PIXELS_BEFORE_HSYNC = 7'h38;
   localparam logic [6:0] IDX_SECOND_CHANNEL_PIXELS_BEFORE_HSYNC = 7'h39;
   localparam logic [6:0] IDX_FIRST_CHANNEL_LINES_BEFORE_VSYNC = 7'h3A;
   localparam logic [6:0] IDX_SECOND_CHANNEL_LINES_BEFORE_VSYNC = 7'h3B;
   localparam logic [6:0] IDX_PATTERN_GENERATOR_ENABLES = 7'h3C;
   localparam logic [6:0] IDX_DSI_B_LEADING_PIXEL_TRIM = 7'h3D;
   localparam logic [6:0] IDX_VIDEO_MODE = 7'h40;
   localparam logic [6:0] IDX_A_HSYNC_WIDTH = 7'h41;
   localparam logic [6:0] IDX_A_VSYNC_WIDTH = 7'h42;
   localparam logic [6:0] IDX_B_HSYNC_WIDTH = 7'h43;
   localparam logic [6:0] IDX_B_VSYNC_WIDTH = 7'h44;
   localparam logic [6:0] IDX_A_LINE_PIXEL_COUNT = 7'h45;
   localparam logic [6:0] IDX_A_FRAME_LINE_COUNT = 7'h46;
   localparam logic [6:0] IDX_SECOND_CHANNEL_LINE_PIXEL_COUNT = 7'h47;
   localparam logic [6:0] IDX_B_FRAME_LINE_COUNT = 7'h48;
   localparam logic [6:0] IDX_STATUS = 7'h49;
   // Slots 0x04..0x0D and 0x10..0x18 hold storage
   localparam logic [31:0] SLOT_RW = 32'h01FF_3FF0;

   // ===================================================================
   // Field positions and reset values
   localparam int PAT_A_BIT = 4;
   localparam int PAT_B_BIT = 0;
   localparam logic [7:0] PAT_WMASK = 8'h11;
   localparam int MODE_CH_LSB = 0;
   localparam int MODE_SINGLE_BIT = 2;
   localparam int MODE_LR_BIT = 3;
   localparam logic [1:0] CH_MODE_SPLIT = 2'b10;
   localparam logic [7:0] REG_RESET = 8'h00;

   // ===================================================================
   // Timing: 50 MHz bus clock, pixel enable every PIX_DIV cycles
   localparam int CLK_MHZ = 50;
   localparam int PIX_DIV = 2;

   typedef enum logic [1:0] {PH_SYNC, PH_BACK, PH_ACT, PH_FRONT} dlb_phase_t;

   function automatic logic [4:0] slot_of(input logic [6:0] idx);
      logic [6:0] d;
      d = idx - IDX_BASE;
      return d[4:0];
   endfunction

endpackage

// ### core/dlb_phase_seq.sv
// One axis of the pattern timing: sync, back porch, active, front porch
`timescale 1ns/100ps
module dlb_phase_seq
   import dlb_pkg::*;
#(
   parameter int W = 8
)(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic run,
   input wire logic step,
   input wire logic [3:0][W-1:0] lens,
   output dlb_phase_t phase_ff,
   output logic [W-1:0] count_ff,
   output logic wrap
);
   logic [1:0] cur;
   logic [1:0] nxt_idx;
   logic found;
   logic last;
   logic adv;

   assign cur = phase_ff;

   // ===================================================================
   // Next phase, zero-length phases skipped
   always_comb
   begin
      found = 1'b0;
      nxt_idx = cur;
      for (int k = 1; k <= 4; k++)
      begin
         if (!found && lens[2'(cur + 2'(k))] != '0)
         begin
            nxt_idx = 2'(cur + 2'(k));
            found = 1'b1;
         end
      end
   end

   assign last = (lens[cur] == '0) || (count_ff == lens[cur] - W'(1));
   assign adv = step & last;
   assign wrap = adv & (nxt_idx <= cur);

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         phase_ff <= PH_SYNC;
         count_ff <= '0;
      end
      else if (!run)
      begin
         phase_ff <= PH_SYNC;
         count_ff <= '0;
      end
      else if (adv)
      begin
         phase_ff <= dlb_phase_t'(nxt_idx);
         count_ff <= '0;
      end
      else if (step)
      begin
         count_ff <= count_ff + W'(1);
      end
   end

   // ===================================================================
   // Checks
   phase_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
      run && step && !last |=> $stable(phase_ff))
      else $error("phase left before its length ran out");
   count_bound_a: assert property (@(posedge hclk) disable iff (!hresetn)
      run && lens[cur] != '0 |-> count_ff < lens[cur])
      else $error("phase count beyond programmed length");

endmodule // dlb_phase_seq

// ### core/dlb_buf2.sv
// Two-entry valid/ready buffer with registered outputs
`timescale 1ns/100ps
module dlb_buf2 #(
   parameter int W = 25
)(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic in_valid,
   input wire logic [W-1:0] in_data,
   output logic in_ready_ff,
   output logic out_valid_ff,
   output logic [W-1:0] out_data_ff,
   input wire logic out_ready
);
   logic skid_valid_ff;
   logic [W-1:0] skid_data_ff;
   logic push;
   logic out_free;

   assign push = in_valid & in_ready_ff;
   assign out_free = out_ready | ~out_valid_ff;

   // Skid entry keeps a word when the receiver stalls
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         out_valid_ff <= 1'b0;
         out_data_ff <= '0;
         skid_valid_ff <= 1'b0;
         skid_data_ff <= '0;
         in_ready_ff <= 1'b1;
      end
      else
      begin
         if (out_free && skid_valid_ff)
         begin
            out_data_ff <= skid_data_ff;
            out_valid_ff <= 1'b1;
            skid_valid_ff <= 1'b0;
            in_ready_ff <= 1'b1;
         end
         else if (out_free)
         begin
            out_valid_ff <= push;
            if (push)
               out_data_ff <= in_data;
         end
         else if (push)
         begin
            skid_data_ff <= in_data;
            skid_valid_ff <= 1'b1;
            in_ready_ff <= 1'b0;
         end
      end
   end

endmodule // dlb_buf2

// ### core/dlb_pattern_trim.sv
// Test-pattern timing generator and DSI channel B leading-pixel trim
`timescale 1ns/100ps
module dlb_pattern_trim
   import dlb_pkg::*;
#(
   parameter int PIX_DIVIDE = PIX_DIV,
   parameter int PIX_W = 24
)(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic [31:0] hrdata,
   output logic hresp,
   input wire logic dsib_valid,
   input wire logic [PIX_W-1:0] dsib_data,
   input wire logic dsib_first,
   output logic dsib_ready,
   output logic crop_valid,
   output logic [PIX_W-1:0] crop_data,
   output logic crop_first,
   input wire logic crop_ready,
   output logic lvds_a_de,
   output logic lvds_a_hs,
   output logic lvds_a_vs,
   output logic [23:0] lvds_a_rgb,
   output logic lvds_b_de,
   output logic lvds_b_hs,
   output logic lvds_b_vs,
   output logic [23:0] lvds_b_rgb
);
   // ===================================================================
   // Pixel-rate enable
   logic [7:0] div_cnt_ff;
   logic pix_en_ff;
   wire div_last = (div_cnt_ff == 8'(PIX_DIVIDE - 1));

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         div_cnt_ff <= 8'h00;
         pix_en_ff <= 1'b0;
      end
      else
      begin
         div_cnt_ff <= div_last ? 8'h00 : div_cnt_ff + 8'h01;
         pix_en_ff <= div_last;
      end
   end

   // ===================================================================
   // Bus slave: writes zero-wait, reads one wait state
   logic wr_pend_ff;
   logic rd_pend_ff;
   logic [6:0] addr_ff;
   logic hreadyout_ff;
   logic [31:0] hrdata_ff;
   logic [7:0] reg_ff [0:SLOTS-1];
   logic [7:0] status_byte;
   wire addr_take = hsel & hready & (htrans == TRANS_NONSEQ);
   wire [6:0] off = addr_ff - IDX_BASE;
   wire in_win = (addr_ff >= IDX_BASE) && (off < 7'(SLOTS));
   wire [4:0] slot = off[4:0];
   wire slot_rw = in_win & SLOT_RW[slot];
   wire is_status = (addr_ff == IDX_STATUS);
   wire [7:0] rd_byte = is_status ? status_byte : (slot_rw ? reg_ff[slot] : 8'h00);
   // Only the two enable bits of the pattern register store anything
   wire [7:0] wr_mask = (addr_ff == IDX_PATTERN_GENERATOR_ENABLES) ? PAT_WMASK : 8'hFF;

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         wr_pend_ff <= 1'b0;
         rd_pend_ff <= 1'b0;
         addr_ff <= 7'h00;
         hreadyout_ff <= 1'b1;
         hrdata_ff <= 32'h0000_0000;
      end
      else
      begin
         wr_pend_ff <= addr_take & hwrite;
         rd_pend_ff <= addr_take & ~hwrite;
         if (addr_take)
            addr_ff <= haddr[8:2];
         hreadyout_ff <= ~(addr_take & ~hwrite);
         if (rd_pend_ff)
            hrdata_ff <= {24'h00_0000, rd_byte};
      end
   end

   assign hreadyout = hreadyout_ff;
   assign hrdata = hrdata_ff;
   assign hresp = HRESP_OKAY;

   for (genvar s = 0; s < SLOTS; s++)
   begin : g_reg
      always_ff @(posedge hclk or negedge hresetn)
      begin
         if (!hresetn)
            reg_ff[s] <= REG_RESET;
         else if (wr_pend_ff && slot_rw && slot == 5'(s))
            reg_ff[s] <= hwdata[7:0] & wr_mask;
      end
   end

   // ===================================================================
   // Mode and field decode
   wire [7:0] mode_r = reg_ff[slot_of(IDX_VIDEO_MODE)];
   wire [7:0] pat_r = reg_ff[slot_of(IDX_PATTERN_GENERATOR_ENABLES)];
   wire [7:0] trim_r = reg_ff[slot_of(IDX_DSI_B_LEADING_PIXEL_TRIM)];
   wire [1:0] ch_mode = mode_r[MODE_CH_LSB +: 2];
   wire lr_mode = mode_r[MODE_LR_BIT];
   wire b_own = (ch_mode == CH_MODE_SPLIT);
   wire share = ~b_own & ~mode_r[MODE_SINGLE_BIT];
   wire [1:0] run;
   assign run[0] = pat_r[PAT_A_BIT];
   assign run[1] = b_own & pat_r[PAT_B_BIT];

   logic [3:0][7:0] h_len [0:1];
   logic [3:0][7:0] v_len [0:1];
   wire [3:0][7:0] a_h = {reg_ff[slot_of(IDX_FIRST_CHANNEL_PIXELS_BEFORE_HSYNC)],
      reg_ff[slot_of(IDX_A_LINE_PIXEL_COUNT)], reg_ff[slot_of(IDX_A_HBP)],
      reg_ff[slot_of(IDX_A_HSYNC_WIDTH)]};
   wire [3:0][7:0] a_v = {reg_ff[slot_of(IDX_FIRST_CHANNEL_LINES_BEFORE_VSYNC)],
      reg_ff[slot_of(IDX_A_FRAME_LINE_COUNT)], reg_ff[slot_of(IDX_A_VBP)],
      reg_ff[slot_of(IDX_A_VSYNC_WIDTH)]};
   wire [3:0][7:0] b_h = {reg_ff[slot_of(IDX_SECOND_CHANNEL_PIXELS_BEFORE_HSYNC)],
      reg_ff[slot_of(IDX_SECOND_CHANNEL_LINE_PIXEL_COUNT)], reg_ff[slot_of(IDX_B_HBP)],
      reg_ff[slot_of(IDX_B_HSYNC_WIDTH)]};
   wire [3:0][7:0] b_v = {reg_ff[slot_of(IDX_SECOND_CHANNEL_LINES_BEFORE_VSYNC)],
      reg_ff[slot_of(IDX_B_FRAME_LINE_COUNT)],
      reg_ff[slot_of(IDX_SECOND_CHANNEL_LINES_AFTER_VSYNC)],
      reg_ff[slot_of(IDX_B_VSYNC_WIDTH)]};

   // B fields are honoured only in split mode; A timing otherwise
   assign h_len[0] = a_h;
   assign v_len[0] = a_v;
   assign h_len[1] = b_own ? b_h : a_h;
   assign v_len[1] = b_own ? b_v : a_v;

   // ===================================================================
   // Pattern generators, one per channel
   dlb_phase_t h_ph [0:1];
   dlb_phase_t v_ph [0:1];
   logic [7:0] h_cnt [0:1];
   logic [7:0] v_cnt [0:1];
   logic [1:0] h_wrap;
   logic [1:0] g_de;
   logic [1:0] g_hs;
   logic [1:0] g_vs;
   logic [23:0] g_rgb [0:1];

   for (genvar c = 0; c < 2; c++)
   begin : g_gen
      dlb_phase_seq #(.W(8)) u_h (
         .hclk(hclk),
         .hresetn(hresetn),
         .run(run[c]),
         .step(pix_en_ff & run[c]),
         .lens(h_len[c]),
         .phase_ff(h_ph[c]),
         .count_ff(h_cnt[c]),
         .wrap(h_wrap[c])
      );
      dlb_phase_seq #(.W(8)) u_v (
         .hclk(hclk),
         .hresetn(hresetn),
         .run(run[c]),
         .step(h_wrap[c]),
         .lens(v_len[c]),
         .phase_ff(v_ph[c]),
         .count_ff(v_cnt[c]),
         .wrap()
      );
      assign g_de[c] = run[c] & (h_ph[c] == PH_ACT) & (v_ph[c] == PH_ACT);
      assign g_hs[c] = run[c] & (h_ph[c] == PH_SYNC);
      assign g_vs[c] = run[c] & (v_ph[c] == PH_SYNC);
      assign g_rgb[c] = g_de[c] ? {h_cnt[c], v_cnt[c], h_cnt[c] ^ v_cnt[c]} : 24'h00_0000;
   end

   // ===================================================================
   // Panel-side outputs; B mirrors A when timing is shared
   logic [1:0] de_ff;
   logic [1:0] hs_ff;
   logic [1:0] vs_ff;
   logic [23:0] rgb_ff [0:1];
   wire b_from_a = share;
   wire b_from_b = b_own;

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         de_ff <= 2'b00;
         hs_ff <= 2'b00;
         vs_ff <= 2'b00;
         rgb_ff[0] <= 24'h00_0000;
         rgb_ff[1] <= 24'h00_0000;
      end
      else if (pix_en_ff)
      begin
         de_ff[0] <= g_de[0];
         hs_ff[0] <= g_hs[0];
         vs_ff[0] <= g_vs[0];
         rgb_ff[0] <= g_rgb[0];
         de_ff[1] <= (b_from_a & g_de[0]) | (b_from_b & g_de[1]);
         hs_ff[1] <= (b_from_a & g_hs[0]) | (b_from_b & g_hs[1]);
         vs_ff[1] <= (b_from_a & g_vs[0]) | (b_from_b & g_vs[1]);
         rgb_ff[1] <= b_from_a ? g_rgb[0] : (b_from_b ? g_rgb[1] : 24'h00_0000);
      end
   end

   assign lvds_a_de = de_ff[0];
   assign lvds_a_hs = hs_ff[0];
   assign lvds_a_vs = vs_ff[0];
   assign lvds_a_rgb = rgb_ff[0];
   assign lvds_b_de = de_ff[1];
   assign lvds_b_hs = hs_ff[1];
   assign lvds_b_vs = vs_ff[1];
   assign lvds_b_rgb = rgb_ff[1];

   // ===================================================================
   // DSI channel B leading-pixel trim
   logic [7:0] pos_ff;
   logic buf_in_ready;
   logic [PIX_W:0] buf_out;
   logic buf_out_valid;
   wire trim_on = lr_mode & (trim_r != 8'h00);
   wire [7:0] pix_idx = dsib_first ? 8'h00 : pos_ff;
   wire drop = trim_on & (pix_idx < trim_r);
   wire keep_first = (pix_idx == (trim_on ? trim_r : 8'h00));
   wire accepted = dsib_valid & buf_in_ready;
   wire push = dsib_valid & ~drop & buf_in_ready;

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         pos_ff <= 8'h00;
      else if (accepted)
         pos_ff <= (pix_idx == 8'hFF) ? 8'hFF : pix_idx + 8'h01;
   end

   // Dropped pixels still wait for room, trading a rare stall for simpler flow
   dlb_buf2 #(.W(PIX_W + 1)) u_buf (
      .hclk(hclk),
      .hresetn(hresetn),
      .in_valid(dsib_valid & ~drop),
      .in_data({keep_first, dsib_data}),
      .in_ready_ff(buf_in_ready),
      .out_valid_ff(buf_out_valid),
      .out_data_ff(buf_out),
      .out_ready(crop_ready)
   );

   assign dsib_ready = buf_in_ready;
   assign crop_valid = buf_out_valid;
   assign crop_data = buf_out[PIX_W-1:0];
   assign crop_first = buf_out[PIX_W];
   assign status_byte = {3'b000, trim_on, g_vs[1], g_vs[0], run[1], run[0]};

   // ===================================================================
   // Checks
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   trim_drop_a: assert property (accepted && trim_on && pix_idx < trim_r |-> !push)
      else $error("trimmed pixel entered the buffer");
   trim_off_a: assert property (dsib_valid && buf_in_ready && !lr_mode |-> push)
      else $error("pixel lost with trim disabled");
   b_hfp_sel_a: assert property (run[1] && h_ph[1] == PH_FRONT |-> h_cnt[1] < b_h[3])
      else $error("channel B front porch not from its own field");
   b_vfp_sel_a: assert property (run[1] && v_ph[1] == PH_FRONT |-> v_cnt[1] < b_v[3])
      else $error("channel B line front porch not from its own field");
   b_vbp_sel_a: assert property (run[1] && v_ph[1] == PH_BACK |-> v_cnt[1] < b_v[1])
      else $error("channel B back porch not from its own field");
   share_timing_a: assert property (share && pix_en_ff |=>
      lvds_b_hs == lvds_a_hs && lvds_b_vs == lvds_a_vs && lvds_b_de == lvds_a_de)
      else $error("shared timing differs between channels");
   a_off_idle_a: assert property (!pat_r[PAT_A_BIT] && pix_en_ff |=>
      !lvds_a_de && !lvds_a_hs && !lvds_a_vs)
      else $error("channel A active without enable");
   b_gate_a: assert property (!share && !(b_own && pat_r[PAT_B_BIT]) && pix_en_ff |=>
      !lvds_b_de && !lvds_b_hs && !lvds_b_vs)
      else $error("channel B active outside split mode");
   a_hfp_run_a: assert property (run[0] && h_ph[0] == PH_FRONT |->
      h_cnt[0] < h_len[0][3])
      else $error("channel A front porch overrun");
   pass_data_a: assert property (accepted && !(trim_on && pix_idx < trim_r) |-> push)
      else $error("converted stream altered by pattern state");
   rd_wait_a: assert property (addr_take && !hwrite |=> !hreadyout ##1 hreadyout)
      else $error("read answer not after one wait state");

   wr_seen_c: cover property (wr_pend_ff && addr_ff == IDX_PATTERN_GENERATOR_ENABLES);
   rd_seen_c: cover property (rd_pend_ff && is_status);
   trim_seen_c: cover property (accepted && drop ##[1:20] push && keep_first);
   b_frame_c: cover property (b_own && $rose(lvds_b_vs));
   stall_c: cover property (dsib_valid && !buf_in_ready);

endmodule // dlb_pattern_trim

// ### testbench/dlb_panel_model.sv
// Panel-side receiver that measures the porch timing of one video channel
`timescale 1ns/100ps
module dlb_panel_model (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic de,
   input wire logic hs,
   input wire logic vs,
   output logic [7:0] hfp_ff,
   output logic [7:0] vbp_ff,
   output logic [7:0] vfp_ff
);
   // ==============================
   // Edge history and counters
   // A panel only samples; it never pushes back on the source
   logic pde_ff, phs_ff, pvs_ff, seen_ff, arm_ff;
   logic [7:0] hc_ff, vc_ff, bc_ff;

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         {pde_ff, phs_ff, pvs_ff, seen_ff, arm_ff} <= '0;
         {hc_ff, vc_ff, bc_ff, hfp_ff, vbp_ff, vfp_ff} <= '0;
      end
      else
      begin
         pde_ff <= de;
         phs_ff <= hs;
         pvs_ff <= vs;
         // Pixels from last active pixel to sync start
         if (de)
         begin
            hc_ff <= '0;
            seen_ff <= 1'b1;
         end
         else if (hs && !phs_ff && seen_ff)
         begin
            hfp_ff <= hc_ff;
            seen_ff <= 1'b0;
         end
         else if (!hs)
            hc_ff <= hc_ff + 8'h01;
         // Lines from last active line to vsync start
         if (de)
            vc_ff <= '0;
         else if (vs && !pvs_ff)
            vfp_ff <= vc_ff;
         else if (hs && !phs_ff && !vs)
            vc_ff <= vc_ff + 8'h01;
         // Lines from vsync end to first active line, less that line itself
         if (vs)
         begin
            bc_ff <= '0;
            arm_ff <= 1'b1;
         end
         else if (de && !pde_ff && arm_ff)
         begin
            vbp_ff <= bc_ff - 8'h01;
            arm_ff <= 1'b0;
         end
         else if (hs && !phs_ff)
            bc_ff <= bc_ff + 8'h01;
      end
   end
endmodule // dlb_panel_model

// ### testbench/test_pattern_timing_crop_tb_top.sv
// Self-checking bench for the pattern timing and trim block
`timescale 1ns/100ps
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin error_cnt++; \
   $display("[ERR] %0t got %0h expected %0h", $time, got, exp); end end
module test_pattern_timing_crop_tb_top
   import dlb_pkg::*;
   ;
   // ==============================
   // Signals
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic hwrite = 1'b0;
   logic [1:0] htrans = 2'h0;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic dsib_valid = 1'b0;
   logic dsib_first = 1'b0;
   logic [23:0] dsib_data = 24'h0;
   logic crop_ready = 1'b0;
   logic hreadyout, hresp, dsib_ready, crop_valid, crop_first;
   logic [31:0] hrdata, rd;
   logic [23:0] crop_data, a_rgb, b_rgb;
   logic a_de, a_hs, a_vs, b_de, b_hs, b_vs;
   logic [7:0] a_hfp, a_vbp, a_vfp, b_hfp, b_vbp, b_vfp, v, hf, vb, vf, t;
   logic [24:0] exp_q[$];
   logic [24:0] exp_px;
   int error_cnt = 0;
   int checks = 0;
   int stall = 0;
   int refused = 0;
   int drop;
   logic [6:0] a_idx[8] = '{IDX_A_HSYNC_WIDTH, IDX_A_HBP, IDX_A_LINE_PIXEL_COUNT,
      IDX_FIRST_CHANNEL_PIXELS_BEFORE_HSYNC, IDX_A_VSYNC_WIDTH, IDX_A_VBP,
      IDX_A_FRAME_LINE_COUNT, IDX_FIRST_CHANNEL_LINES_BEFORE_VSYNC};
   logic [6:0] b_idx[8] = '{IDX_B_HSYNC_WIDTH, IDX_B_HBP, IDX_SECOND_CHANNEL_LINE_PIXEL_COUNT,
      IDX_SECOND_CHANNEL_PIXELS_BEFORE_HSYNC, IDX_B_VSYNC_WIDTH,
      IDX_SECOND_CHANNEL_LINES_AFTER_VSYNC, IDX_B_FRAME_LINE_COUNT,
      IDX_SECOND_CHANNEL_LINES_BEFORE_VSYNC};

   // ==============================
   // Design and panels
   // One pixel per clock keeps frames short
   dlb_pattern_trim #(.PIX_DIVIDE(1), .PIX_W(24)) i_dlb_pattern_trim (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
      .dsib_valid(dsib_valid), .dsib_data(dsib_data), .dsib_first(dsib_first),
      .dsib_ready(dsib_ready), .crop_valid(crop_valid), .crop_data(crop_data),
      .crop_first(crop_first), .crop_ready(crop_ready),
      .lvds_a_de(a_de), .lvds_a_hs(a_hs), .lvds_a_vs(a_vs), .lvds_a_rgb(a_rgb),
      .lvds_b_de(b_de), .lvds_b_hs(b_hs), .lvds_b_vs(b_vs), .lvds_b_rgb(b_rgb));
   dlb_panel_model i_panel_a (.hclk(hclk), .hresetn(hresetn), .de(a_de), .hs(a_hs),
      .vs(a_vs), .hfp_ff(a_hfp), .vbp_ff(a_vbp), .vfp_ff(a_vfp));
   dlb_panel_model i_panel_b (.hclk(hclk), .hresetn(hresetn), .de(b_de), .hs(b_hs),
      .vs(b_vs), .hfp_ff(b_hfp), .vbp_ff(b_vbp), .vfp_ff(b_vfp));

   // ==============================
   // Clock, watchdog, trimmed-pixel receiver
   initial
   begin
      forever #10 hclk = ~hclk;
   end

   initial
   begin
      #800000;
      error_cnt++;
      close_out();
   end

   // Stalls at the start of each line so the two-entry buffer fills
   always @(posedge hclk)
   begin
      crop_ready <= (stall == 0) && ($urandom_range(3, 0) != 0);
      if (stall > 0)
         stall--;
      if (dsib_ready === 1'b0)
         refused++;
      if (crop_valid === 1'b1 && crop_ready === 1'b1)
      begin
         exp_px = (exp_q.size() > 0) ? exp_q.pop_front() : 'x;
         `CHK({crop_first, crop_data}, exp_px)
      end
   end

   // ==============================
   // Tasks
   task automatic close_out();
      if (error_cnt == 0 && checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   task automatic ahb(input logic [6:0] idx, input logic wr, input logic [7:0] wd);
      hsel <= 1'b1;
      htrans <= TRANS_NONSEQ;
      haddr <= {23'h0, idx, 2'h0};
      hwrite <= wr;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= {24'h0, wd};
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
      `CHK(hresp, HRESP_OKAY)
   endtask

   task automatic set_timing(input logic [6:0] idx[8]);
      logic [7:0] val[8];
      hf = 8'($urandom_range(3, 0));
      vb = 8'($urandom_range(3, 0));
      vf = 8'($urandom_range(3, 0));
      val = '{8'h01, 8'h01, 8'h04, hf, 8'h01, vb, 8'h02, vf};
      foreach (idx[i])
         ahb(idx[i], 1'b1, val[i]);
   endtask

   task automatic push(input logic [23:0] d, input logic f, input logic keep, input logic kf);
      if ($urandom_range(2, 0) == 0)
      begin
         dsib_valid <= 1'b0;
         @(posedge hclk);
      end
      dsib_valid <= 1'b1;
      dsib_data <= d;
      dsib_first <= f;
      do @(posedge hclk); while (dsib_ready !== 1'b1);
      if (keep)
         exp_q.push_back({kf, d});
   endtask

   // ==============================
   // Main sequence
   initial
   begin
      void'($urandom(32'hAA40));
      repeat (16) @(posedge hclk);
      hresetn <= 1'b1;
      for (int i = 0; i < 7; i++)
      begin
         ahb(IDX_SECOND_CHANNEL_LINES_AFTER_VSYNC + 7'(i), 1'b0, 8'h00);
         `CHK(rd, 32'h0)
      end
      for (int i = 0; i < 7; i++)
      begin
         v = 8'($urandom);
         ahb(IDX_SECOND_CHANNEL_LINES_AFTER_VSYNC + 7'(i), 1'b1, v);
         ahb(IDX_SECOND_CHANNEL_LINES_AFTER_VSYNC + 7'(i), 1'b0, 8'h00);
         `CHK(rd, {24'h0, (i == 5) ? (v & PAT_WMASK) : v})
      end
      ahb(7'h3E, 1'b1, 8'hFF);
      ahb(7'h3E, 1'b0, 8'h00);
      `CHK(rd, 32'h0)
      ahb(IDX_PATTERN_GENERATOR_ENABLES, 1'b1, 8'h00);
      // Channel A alone on a single link
      ahb(IDX_VIDEO_MODE, 1'b1, 8'h04);
      set_timing(a_idx);
      // B bit set as well: it must stay without effect outside split mode
      ahb(IDX_PATTERN_GENERATOR_ENABLES, 1'b1, 8'h11);
      repeat (3) @(posedge a_vs);
      `CHK(a_hfp, hf)
      `CHK(a_vfp, vf)
      `CHK(a_vbp, vb)
      ahb(IDX_STATUS, 1'b0, 8'h00);
      `CHK(rd & 32'hFFFF_FFFB, 32'h0000_0001)
      `CHK({b_de, b_hs, b_vs}, 3'h0)
      // Channel B with its own timing in split mode
      ahb(IDX_PATTERN_GENERATOR_ENABLES, 1'b1, 8'h00);
      ahb(IDX_VIDEO_MODE, 1'b1, 8'h02);
      set_timing(b_idx);
      ahb(IDX_PATTERN_GENERATOR_ENABLES, 1'b1, 8'h01);
      repeat (3) @(posedge b_vs);
      `CHK(b_hfp, hf)
      `CHK(b_vbp, vb)
      `CHK(b_vfp, vf)
      `CHK(a_de, 1'b0)
      ahb(IDX_STATUS, 1'b0, 8'h00);
      `CHK(rd & 32'hFFFF_FFF7, 32'h0000_0002)
      // Shared timing: B follows A, its own enable ignored; modes 00 and 11
      for (int e = 0; e < 3; e++)
      begin
         ahb(IDX_VIDEO_MODE, 1'b1, (e == 2) ? 8'h03 : 8'h00);
         ahb(IDX_PATTERN_GENERATOR_ENABLES, 1'b1, e[0] ? 8'h01 : 8'h11);
         repeat (4) @(posedge hclk);
         repeat (100)
         begin
            @(negedge hclk);
            `CHK({b_de, b_hs, b_vs, b_rgb}, e[0] ? 27'h0 : {a_de, a_hs, a_vs, a_rgb})
            `CHK(a_de | (a_rgb == 24'h00_0000), 1'b1)
         end
      end
      // Trim on, trim ignored outside left/right, trim zero
      ahb(IDX_PATTERN_GENERATOR_ENABLES, 1'b1, 8'h00);
      for (int c = 0; c < 3; c++)
      begin
         t = (c == 2) ? 8'h00 : 8'($urandom_range(4, 1));
         drop = (c == 1) ? 0 : int'(t);
         ahb(IDX_VIDEO_MODE, 1'b1, (c == 1) ? 8'h00 : 8'h08);
         ahb(IDX_DSI_B_LEADING_PIXEL_TRIM, 1'b1, t);
         ahb(IDX_SECOND_CHANNEL_LINE_PIXEL_COUNT, 1'b1, 8'(8 - drop));
         stall = 12;
         for (int p = 0; p < 8; p++)
            push(24'($urandom), p == 0, p >= drop, p == drop);
         dsib_valid <= 1'b0;
         for (int w = 0; w < 100 && exp_q.size() > 0; w++)
            @(posedge hclk);
         `CHK(exp_q.size(), 0)
      end
      `CHK(refused > 0, 1'b1)
      close_out();
   end
endmodule // test_pattern_timing_crop_tb_top
